// *** src/modem_cfg.svh ***
// Constants for the radio modem command block
`ifndef MODEM_CFG_SVH
`define MODEM_CFG_SVH
`define CLK_HZ 20000000
`define CLK_PERIOD_NS 50
`define UPGRADE_TIME_S 60
`define RELOAD_TIME_US 100
`define RELOAD_CYCLES ((`RELOAD_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BAUD_MAX 3'h7
`define PARITY_MAX 2'h3
`define CHANNEL_MAX 16'h0050
`define NETID_MAX 16'h00ff
`define BAUD_UPGRADE 3'h7
`define MODE_SLEEP 2'h3
`define MODE_CONFIG 2'h2
`define MODE_GENERAL 2'h0
// Arbitrary identification value
`define DEVICE_ID 32'h00c0ffee
`define OFS_SERIAL 8'h00
`define OFS_RADIO 8'h04
`define OFS_WOR 8'h08
`define OFS_SWITCH 8'h0c
`define OFS_ADDR 8'h10
`define OFS_NET 8'h14
`define OFS_STATUS 8'h18
`define OFS_BAUD_BPS 8'h1c
`define OFS_CONTROL 8'h20
`define OFS_ID 8'h24
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RST_BAUD 3'h3
`define RST_CHANNEL 8'h12
`endif

// *** src/modem_pkg.sv ***
// Types shared by the radio modem command block
package modem_pkg;
  typedef enum logic [3:0] {
    CMD_UART = 4'h0, CMD_RATE = 4'h1, CMD_PACKET = 4'h2, CMD_WOR = 4'h3,
    CMD_POWER = 4'h4, CMD_TRANS = 4'h5, CMD_ROUTER = 4'h6, CMD_LBT = 4'h7,
    CMD_ERSSI = 4'h8, CMD_DRSSI = 4'h9, CMD_ADDR = 4'ha, CMD_CHANNEL = 4'hb,
    CMD_NETID = 4'hc, CMD_KEY = 4'hd, CMD_DELAY = 4'he, CMD_UPGRADE = 4'hf
  } cmd_t;

  typedef struct packed {
    cmd_t cmd;
    logic query;
    logic [15:0] arg0;
    logic [15:0] arg1;
  } cmd_req_t;

  typedef struct packed {
    cmd_t cmd;
    logic ok;
    logic [15:0] val0;
    logic [15:0] val1;
  } cmd_rsp_t;

  typedef struct packed {
    logic [2:0] baud;
    logic [1:0] parity;
    logic [2:0] airRate;
    logic [1:0] packet;
    logic worRole;
    logic [2:0] worPeriod;
    logic [1:0] power;
    logic transMode;
    logic relayEn;
    logic lbtEn;
    logic noiseRssiEn;
    logic dataRssiEn;
    logic [15:0] address;
    logic [7:0] channel;
    logic [7:0] netId;
    logic [15:0] cryptKey;
    logic [15:0] sleepDelay;
  } settings_t;

  typedef struct packed {
    logic [7:0] netId;
    logic [15:0] srcAddr;
    logic [7:0] data;
  } frame_t;
endpackage

// *** src/radio_modem_cmd.sv ***
// Radio modem command decoder, upgrade mode, relay forwarding and AXI4-Lite registers
`timescale 1ns/1ps
`include "modem_cfg.svh"

module radio_modem_cmd
  import modem_pkg::*;
#(
  parameter int unsigned UPGRADE_CYCLES = `UPGRADE_TIME_S * `CLK_HZ,
  parameter int unsigned RELOAD_CYCLES = `RELOAD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pwrOnRst,
  input wire logic modeSelectLow,
  input wire logic modeSelectHigh,
  input wire logic cmdValid,
  input wire cmd_req_t cmdReq,
  output logic rspValid,
  output cmd_rsp_t rspData,
  input wire logic rxValid,
  input wire frame_t rxFrame,
  output logic fwdValid,
  output frame_t fwdFrame,
  output logic userOutValid,
  output logic [7:0] userOutData,
  output logic userPortEn,
  output logic lowPowerAllowed,
  output logic upgradeMode,
  output logic logEnable,
  output logic [2:0] baudCode,
  output logic [1:0] parityCode,
  output logic aux,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Zero counts would skip the reload or leave upgrade pending for 2^32 cycles
  if (UPGRADE_CYCLES < 1 || RELOAD_CYCLES < 1) begin
    $error("cycle counts must be at least one");
  end

  // ----------------------------------------------------------------
  // Field decoding
  // ----------------------------------------------------------------
  function automatic logic [31:0] baudBps(input logic [2:0] code);
    unique case (code)
      3'h0: baudBps = 32'h000004b0;
      3'h1: baudBps = 32'h00000960;
      3'h2: baudBps = 32'h000012c0;
      3'h3: baudBps = 32'h00002580;
      3'h4: baudBps = 32'h00004b00;
      3'h5: baudBps = 32'h00009600;
      3'h6: baudBps = 32'h0000e100;
      3'h7: baudBps = 32'h0001c200;
    endcase
  endfunction

  // Air rate in units of 100 bit/s
  function automatic logic [9:0] airRate100(input logic [2:0] code);
    unique case (code)
      3'h0, 3'h1, 3'h2: airRate100 = 10'h018;
      3'h3: airRate100 = 10'h030;
      3'h4: airRate100 = 10'h060;
      3'h5: airRate100 = 10'h0c0;
      3'h6: airRate100 = 10'h180;
      3'h7: airRate100 = 10'h271;
    endcase
  endfunction

  function automatic logic [7:0] packetBytes(input logic [1:0] code);
    unique case (code)
      2'h0: packetBytes = 8'hf0;
      2'h1: packetBytes = 8'h80;
      2'h2: packetBytes = 8'h40;
      2'h3: packetBytes = 8'h20;
    endcase
  endfunction

  // Period = (code + 1) * 500 ms
  function automatic logic [11:0] periodMs(input logic [2:0] code);
    periodMs = (12'(code) + 12'h001) * 12'h1f4;
  endfunction

  function automatic logic [5:0] powerDbm(input logic [1:0] code);
    powerDbm = 6'h21 - 6'(code) * 6'h03;
  endfunction

  // ----------------------------------------------------------------
  // Mode, reload and upgrade state
  // ----------------------------------------------------------------
  logic [1:0] mode;
  logic [1:0] prevMode;
  logic [31:0] reloadCnt;
  logic [31:0] upgradeCnt;
  logic upgradePending;
  logic reloading;
  logic relayActive;
  logic acceptCmds;
  settings_t cfg;

  assign mode = {modeSelectHigh, modeSelectLow};
  assign reloading = (reloadCnt != 32'h0);
  assign relayActive = cfg.relayEn && (mode == `MODE_GENERAL) && !reloading;

  always_ff @(posedge sys_clk) begin
    if (srst || pwrOnRst) begin
      prevMode <= `MODE_GENERAL;
    end else begin
      prevMode <= mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || pwrOnRst) begin
      reloadCnt <= RELOAD_CYCLES;
    end else if (prevMode == `MODE_SLEEP && mode != `MODE_SLEEP) begin
      reloadCnt <= RELOAD_CYCLES;
    end else if (reloading) begin
      reloadCnt <= reloadCnt - 32'h1;
    end
  end

  // Pending flag survives a restart, only power-on or the timer clears it
  always_ff @(posedge sys_clk) begin
    if (pwrOnRst) begin
      upgradePending <= 1'b0;
      upgradeCnt <= 32'h0;
    end else if (srst) begin
      upgradeCnt <= 32'h0;
    end else if (cmdValid && acceptCmds && !cmdReq.query && cmdReq.cmd == CMD_UPGRADE) begin
      upgradePending <= 1'b1;
      upgradeCnt <= 32'h0;
    end else if (upgradePending) begin
      if (upgradeCnt == UPGRADE_CYCLES - 1) begin
        upgradePending <= 1'b0;
        upgradeCnt <= 32'h0;
      end else begin
        upgradeCnt <= upgradeCnt + 32'h1;
      end
    end
  end

  assign upgradeMode = upgradePending;
  assign logEnable = upgradePending;
  assign baudCode = upgradePending ? `BAUD_UPGRADE : cfg.baud;
  assign parityCode = cfg.parity;
  assign aux = !reloading;
  assign userPortEn = !relayActive && !upgradePending;
  assign lowPowerAllowed = !relayActive;

  // ----------------------------------------------------------------
  // Command checking and settings
  // ----------------------------------------------------------------
  logic ctrlAnyMode;
  logic cmdOk;
  logic [15:0] qVal0;
  logic [15:0] qVal1;

  assign acceptCmds = !reloading && (ctrlAnyMode || mode == `MODE_CONFIG);

  always_comb begin
    cmdOk = 1'b1;
    qVal0 = 16'h0;
    qVal1 = 16'h0;
    unique case (cmdReq.cmd)
      CMD_UART: begin
        cmdOk = cmdReq.arg0 <= 16'(`BAUD_MAX) && cmdReq.arg1 <= 16'(`PARITY_MAX);
        qVal0 = 16'(cfg.baud);
        qVal1 = 16'(cfg.parity);
      end
      CMD_RATE: begin
        cmdOk = cmdReq.arg0 <= 16'h7;
        qVal0 = 16'(cfg.airRate);
      end
      CMD_PACKET: begin
        cmdOk = cmdReq.arg0 <= 16'h3;
        qVal0 = 16'(cfg.packet);
      end
      CMD_WOR: begin
        cmdOk = cmdReq.arg0 <= 16'h1 && cmdReq.arg1 <= 16'h7;
        qVal0 = 16'(cfg.worRole);
        qVal1 = 16'(cfg.worPeriod);
      end
      CMD_POWER: begin
        cmdOk = cmdReq.arg0 <= 16'h3;
        qVal0 = 16'(cfg.power);
      end
      CMD_TRANS, CMD_ROUTER, CMD_LBT, CMD_ERSSI, CMD_DRSSI: begin
        cmdOk = cmdReq.arg0 <= 16'h1;
        qVal0 = 16'(cmdReq.cmd == CMD_TRANS ? cfg.transMode :
                    cmdReq.cmd == CMD_ROUTER ? cfg.relayEn :
                    cmdReq.cmd == CMD_LBT ? cfg.lbtEn :
                    cmdReq.cmd == CMD_ERSSI ? cfg.noiseRssiEn : cfg.dataRssiEn);
      end
      CMD_ADDR: qVal0 = cfg.address;
      CMD_CHANNEL: begin
        cmdOk = cmdReq.arg0 <= `CHANNEL_MAX;
        qVal0 = 16'(cfg.channel);
      end
      CMD_NETID: begin
        cmdOk = cmdReq.arg0 <= `NETID_MAX;
        qVal0 = 16'(cfg.netId);
      end
      CMD_KEY: cmdOk = !cmdReq.query;
      CMD_DELAY: qVal0 = cfg.sleepDelay;
      CMD_UPGRADE: cmdOk = !cmdReq.query;
    endcase
    if (cmdReq.query && cmdReq.cmd != CMD_KEY && cmdReq.cmd != CMD_UPGRADE) begin
      cmdOk = 1'b1;
    end
    if (!acceptCmds) begin
      cmdOk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (pwrOnRst) begin
      cfg <= '0;
      cfg.baud <= `RST_BAUD;
      cfg.channel <= `RST_CHANNEL;
    end else if (cmdValid && cmdOk && !cmdReq.query) begin
      unique case (cmdReq.cmd)
        CMD_UART: begin
          cfg.baud <= cmdReq.arg0[2:0];
          cfg.parity <= cmdReq.arg1[1:0];
        end
        CMD_RATE: cfg.airRate <= cmdReq.arg0[2:0];
        CMD_PACKET: cfg.packet <= cmdReq.arg0[1:0];
        CMD_WOR: begin
          cfg.worRole <= cmdReq.arg0[0];
          cfg.worPeriod <= cmdReq.arg1[2:0];
        end
        CMD_POWER: cfg.power <= cmdReq.arg0[1:0];
        CMD_TRANS: cfg.transMode <= cmdReq.arg0[0];
        CMD_ROUTER: cfg.relayEn <= cmdReq.arg0[0];
        CMD_LBT: cfg.lbtEn <= cmdReq.arg0[0];
        CMD_ERSSI: cfg.noiseRssiEn <= cmdReq.arg0[0];
        CMD_DRSSI: cfg.dataRssiEn <= cmdReq.arg0[0];
        CMD_ADDR: cfg.address <= cmdReq.arg0;
        CMD_CHANNEL: cfg.channel <= cmdReq.arg0[7:0];
        CMD_NETID: cfg.netId <= cmdReq.arg0[7:0];
        CMD_KEY: cfg.cryptKey <= cmdReq.arg0;
        CMD_DELAY: cfg.sleepDelay <= cmdReq.arg0;
        CMD_UPGRADE: cfg <= cfg;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || pwrOnRst) begin
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      rspValid <= cmdValid;
      if (cmdValid) begin
        rspData.cmd <= cmdReq.cmd;
        rspData.ok <= cmdOk;
        rspData.val0 <= (cmdReq.query && cmdOk) ? qVal0 : 16'h0;
        rspData.val1 <= (cmdReq.query && cmdOk) ? qVal1 : 16'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Radio frames: relay forwarding and local delivery
  // ----------------------------------------------------------------
  logic [7:0] pairHigh;
  logic [7:0] pairLow;

  assign pairHigh = cfg.address[15:8];
  assign pairLow = cfg.address[7:0];

  always_ff @(posedge sys_clk) begin
    if (srst || pwrOnRst) begin
      fwdValid <= 1'b0;
      fwdFrame <= '0;
      userOutValid <= 1'b0;
      userOutData <= 8'h0;
    end else begin
      fwdValid <= 1'b0;
      userOutValid <= 1'b0;
      if (rxValid && relayActive) begin
        fwdFrame <= rxFrame;
        if (rxFrame.netId == pairHigh) begin
          fwdValid <= 1'b1;
          fwdFrame.netId <= pairLow;
        end else if (rxFrame.netId == pairLow) begin
          fwdValid <= 1'b1;
          fwdFrame.netId <= pairHigh;
        end
      end else if (rxValid && userPortEn && !reloading) begin
        if (rxFrame.srcAddr == cfg.address && rxFrame.netId == cfg.netId) begin
          userOutValid <= 1'b1;
          userOutData <= rxFrame.data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [31:0] rdWord;
  logic rdHit;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (srst || pwrOnRst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrlAnyMode <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({awAddr[7:2], 2'h0} == `OFS_CONTROL) begin
          s_axi_bresp <= `RESP_OKAY;
          if (wStrb[0]) begin
            ctrlAnyMode <= wData[0];
          end
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rdHit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'h0})
      `OFS_SERIAL: rdWord = {27'h0, cfg.parity, cfg.baud};
      `OFS_RADIO: rdWord = {powerDbm(cfg.power), packetBytes(cfg.packet),
                            airRate100(cfg.airRate), cfg.transMode, cfg.power,
                            cfg.packet, cfg.airRate};
      `OFS_WOR: rdWord = {cfg.sleepDelay, periodMs(cfg.worPeriod), cfg.worRole, cfg.worPeriod};
      `OFS_SWITCH: rdWord = {28'h0, cfg.dataRssiEn, cfg.noiseRssiEn, cfg.lbtEn, cfg.relayEn};
      `OFS_ADDR: rdWord = {16'h0, cfg.address};
      `OFS_NET: rdWord = {16'h0, cfg.netId, cfg.channel};
      `OFS_STATUS: rdWord = {26'h0, userPortEn, aux, relayActive, upgradePending, mode};
      `OFS_BAUD_BPS: rdWord = baudBps(baudCode);
      `OFS_CONTROL: rdWord = {31'h0, ctrlAnyMode};
      `OFS_ID: rdWord = `DEVICE_ID;
      default: begin
        rdWord = 32'h0;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst || pwrOnRst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdWord;
      s_axi_rresp <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** sim/radio_modem_cmd_checker.sv ***
// Assertion checker for the radio modem command block
`timescale 1ns/1ps
module radio_modem_cmd_checker
  import modem_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pwrOnRst,
  input wire logic cmdValid,
  input wire cmd_req_t cmdReq,
  input wire logic rspValid,
  input wire cmd_rsp_t rspData,
  input wire logic rxValid,
  input wire frame_t rxFrame,
  input wire logic fwdValid,
  input wire frame_t fwdFrame,
  input wire logic userOutValid,
  input wire logic [7:0] userOutData,
  input wire logic userPortEn,
  input wire logic lowPowerAllowed,
  input wire logic upgradeMode,
  input wire logic logEnable,
  input wire logic [2:0] baudCode,
  input wire logic aux
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst || pwrOnRst);

  property p_rsp_next;
    cmdValid |=> rspValid && rspData.cmd == $past(cmdReq.cmd);
  endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no answer after command");
  property p_rsp_cause;
    rspValid |-> $past(cmdValid);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
  property p_key_query;
    cmdValid && cmdReq.cmd == CMD_KEY && cmdReq.query |=> !rspData.ok && rspData.val0 == '0;
  endproperty
  a_key_query: assert property (p_key_query) else $error("key query answered");
  property p_chan_range;
    cmdValid && cmdReq.cmd == CMD_CHANNEL && !cmdReq.query && cmdReq.arg0 > 16'h0050
      |=> !rspData.ok;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel above range taken");
  property p_upg_enter;
    cmdValid && cmdReq.cmd == CMD_UPGRADE && !cmdReq.query ##1 rspData.ok |-> ##[0:1] upgradeMode;
  endproperty
  a_upg_enter: assert property (p_upg_enter) else $error("upgrade not entered");
  property p_upg_port;
    upgradeMode |-> baudCode == 3'h7 && logEnable && !userPortEn;
  endproperty
  a_upg_port: assert property (p_upg_port) else $error("upgrade port setup wrong");
  property p_fwd_cause;
    fwdValid |-> $past(rxValid) && fwdFrame.data == $past(rxFrame.data)
      && fwdFrame.srcAddr == $past(rxFrame.srcAddr);
  endproperty
  a_fwd_cause: assert property (p_fwd_cause) else $error("forwarded frame wrong");
  property p_relay_port;
    fwdValid |-> !lowPowerAllowed && !userPortEn && !userOutValid;
  endproperty
  a_relay_port: assert property (p_relay_port) else $error("relay allows port or sleep");
  property p_user_cause;
    userOutValid |-> $past(rxValid) && userOutData == $past(rxFrame.data);
  endproperty
  a_user_cause: assert property (p_user_cause) else $error("user output without frame");
  property p_aux_reload;
    $fell(srst) |-> !aux ##1 !aux;
  endproperty
  a_aux_reload: assert property (p_aux_reload) else $error("aux high during reload");

  c_fwd: cover property (fwdValid);
  c_user: cover property (userOutValid);
  c_upg: cover property ($fell(upgradeMode));
endmodule

bind radio_modem_cmd radio_modem_cmd_checker radio_modem_cmd_checker_i (
  .sys_clk, .srst, .pwrOnRst, .cmdValid, .cmdReq, .rspValid, .rspData, .rxValid, .rxFrame,
  .fwdValid, .fwdFrame, .userOutValid, .userOutData, .userPortEn, .lowPowerAllowed,
  .upgradeMode, .logEnable, .baudCode, .aux
);

// *** sim/host_model.sv ***
// Host controller model issuing decoded commands
`timescale 1ns/1ps
module host_model
  import modem_pkg::*;
(
  input wire logic sys_clk,
  output logic cmdValid,
  output cmd_req_t cmdReq,
  input wire logic rspValid,
  input wire cmd_rsp_t rspData
);
  cmd_rsp_t lastRsp;
  logic gotRsp;
  initial begin
    cmdValid = 1'b0;
    cmdReq = '0;
  end
  // ----
  // One command, answer taken one edge later
  // ----
  task automatic send(input cmd_t c, input logic q, input logic [15:0] a0, input logic [15:0] a1);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdReq <= '{c, q, a0, a1};
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdReq <= ~cmdReq;
    @(posedge sys_clk);
    gotRsp = rspValid;
    lastRsp = rspData;
  endtask
endmodule

// *** sim/tb.sv ***
// Self-checking testbench for the radio modem command block
`timescale 1ns/1ps
module tb
  import modem_pkg::*;
;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic pwrOnRst = 1'b1;
  logic modeSelectLow = 1'b0;
  logic modeSelectHigh = 1'b1;
  logic rxValid = 1'b0;
  frame_t rxFrame = '0;
  logic cmdValid, rspValid, fwdValid, userOutValid, userPortEn, lowPowerAllowed;
  logic upgradeMode, logEnable, aux, fv, uv;
  cmd_req_t cmdReq;
  cmd_rsp_t rspData;
  frame_t fwdFrame, ff;
  logic [7:0] userOutData, ud;
  logic [2:0] baudCode;
  logic [1:0] parityCode, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] d;
  int fails = 0, checks_done = 0, cyc = 0, p, n;
  cmd_t cl[10] = '{CMD_RATE, CMD_PACKET, CMD_POWER, CMD_TRANS, CMD_ROUTER, CMD_LBT,
    CMD_ERSSI, CMD_DRSSI, CMD_CHANNEL, CMD_NETID};
  int mx[10] = '{7, 3, 3, 1, 1, 1, 1, 1, 80, 255};

  radio_modem_cmd #(.UPGRADE_CYCLES(50), .RELOAD_CYCLES(4)) radio_modem_cmd_i (
    .sys_clk, .srst, .pwrOnRst, .modeSelectLow, .modeSelectHigh, .cmdValid, .cmdReq,
    .rspValid, .rspData, .rxValid, .rxFrame, .fwdValid, .fwdFrame, .userOutValid,
    .userOutData, .userPortEn, .lowPowerAllowed, .upgradeMode, .logEnable, .baudCode,
    .parityCode, .aux, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  host_model host_model_i (.sys_clk, .cmdValid, .cmdReq, .rspValid, .rspData);

  always #25 sys_clk = ~sys_clk;

  // ----
  // Helpers
  // ----
  task automatic summarize();
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] bpsOf(input int c);
    logic [31:0] t[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    return t[c];
  endfunction
  task automatic cmd(input cmd_t c, input logic q, input logic [15:0] a0, input logic [15:0] a1,
      input logic ok);
    host_model_i.send(c, q, a0, a1);
    chk("rsp valid", 1'b1, host_model_i.gotRsp);
    chk("rsp ok", ok, host_model_i.lastRsp.ok);
  endtask
  task automatic frm(input logic [7:0] nt, input logic [15:0] s, input logic [7:0] dt);
    @(posedge sys_clk);
    rxValid <= 1'b1;
    rxFrame <= '{nt, s, dt};
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxFrame <= '{~nt, ~s, ~dt};
    @(posedge sys_clk);
    fv = fwdValid;
    ff = fwdFrame;
    uv = userOutValid;
    ud = userOutData;
  endtask
  task automatic waitAux();
    for (int i = 0; i < 40 && aux !== 1'b1; i++) @(posedge sys_clk);
    chk("aux", 1'b1, aux);
  endtask
  task automatic wrChk(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~dt;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(74097));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    pwrOnRst <= 1'b0;
    cmd(CMD_CHANNEL, 1'b0, 16'h0005, '0, 1'b0);
    chk("aux", 1'b0, aux);
    waitAux();
    rdChk("status", 8'h18, 32'h32, 2'h0);
    rdChk("id", 8'h24, 32'h00c0ffee, 2'h0);
    rdChk("serial", 8'h00, 32'h3, 2'h0);
    rdChk("net", 8'h14, 32'h12, 2'h0);
    foreach (cl[i]) begin
      for (int v = 0; v <= mx[i] + 1; v++)
        cmd(cl[i], 1'b0, v[15:0], '0, v <= mx[i]);
      cmd(cl[i], 1'b1, '0, '0, 1'b1);
      chk("query", mx[i], host_model_i.lastRsp.val0);
    end
    rdChk("radio", 8'h04, {6'h18, 8'h20, 10'h271, 1'b1, 2'h3, 2'h3, 3'h7}, 2'h0);
    for (int b = 0; b < 8; b++) begin
      cmd(CMD_UART, 1'b0, b[15:0], {14'h0, b[1:0]}, 1'b1);
      rdChk("bps", 8'h1c, bpsOf(b), 2'h0);
      chk("parity", b[1:0], parityCode);
    end
    cmd(CMD_UART, 1'b0, 16'h0008, '0, 1'b0);
    cmd(CMD_UART, 1'b0, '0, 16'h0004, 1'b0);
    chk("baud", 3'h7, baudCode);
    cmd(CMD_UART, 1'b0, 16'h0001, '0, 1'b1);
    p = $urandom % 8;
    d = 16'($urandom);
    cmd(CMD_WOR, 1'b0, 16'h0001, p[15:0], 1'b1);
    cmd(CMD_DELAY, 1'b0, d, '0, 1'b1);
    cmd(CMD_WOR, 1'b0, 16'h0002, '0, 1'b0);
    rdChk("wor", 8'h08, {d, 12'(500 * (p + 1)), 1'b1, p[2:0]}, 2'h0);
    cmd(CMD_KEY, 1'b0, 16'($urandom), '0, 1'b1);
    cmd(CMD_KEY, 1'b1, '0, '0, 1'b0);
    chk("key", '0, host_model_i.lastRsp.val0);
    cmd(CMD_ADDR, 1'b0, {8'h02, 8'h0a}, '0, 1'b1);
    rdChk("addr", 8'h10, 32'h20a, 2'h0);
    rdChk("unmapped", 8'h28, '0, 2'h2);
    wrChk(8'h00, 32'h0, 2'h2);
    wrChk(8'h20, 32'h1, 2'h0);
    rdChk("control", 8'h20, 32'h1, 2'h0);
    wrChk(8'h20, 32'h0, 2'h0);
    frm(8'h02, 16'h0007, 8'h5a);
    chk("fwd", 1'b0, fv);
    modeSelectHigh <= 1'b0;
    frm(8'h02, 16'h0007, 8'h5a);
    chk("fwd valid", 1'b1, fv);
    chk("fwd frame", {8'h0a, 16'h0007, 8'h5a}, ff);
    frm(8'h0a, 16'h0009, 8'ha5);
    chk("fwd valid", 1'b1, fv);
    chk("fwd frame", {8'h02, 16'h0009, 8'ha5}, ff);
    frm(8'hff, 16'h020a, 8'h33);
    chk("fwd or out", '0, {fv, uv});
    chk("relay port", '0, {lowPowerAllowed, userPortEn});
    modeSelectHigh <= 1'b1;
    cmd(CMD_ROUTER, 1'b0, '0, '0, 1'b1);
    modeSelectHigh <= 1'b0;
    frm(8'hff, 16'h020a, 8'h33);
    chk("user out", {1'b1, 8'h33}, {uv, ud});
    frm(8'hff, 16'h020b, 8'h44);
    chk("user out", '0, uv);
    chk("low power", 1'b1, lowPowerAllowed);
    modeSelectLow <= 1'b1;
    modeSelectHigh <= 1'b1;
    repeat (3) @(posedge sys_clk);
    modeSelectLow <= 1'b0;
    modeSelectHigh <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("aux", 1'b0, aux);
    waitAux();
    modeSelectHigh <= 1'b1;
    cmd(CMD_UPGRADE, 1'b0, '0, '0, 1'b1);
    chk("upgrade", 5'h1f, {upgradeMode, logEnable, baudCode});
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk("upgrade kept", 1'b1, upgradeMode);
    n = 0;
    while (upgradeMode === 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("upgrade cycles", 1'b1, n >= 45 && n <= 55);
    chk("baud", 3'h1, baudCode);
    rdChk("serial kept", 8'h00, 32'h1, 2'h0);
    summarize();
  end
endmodule
